// ===== bench/ocd_sink_model.sv
// downstream clock sink that counts divided channel ticks
`timescale 1ns/100ps
module ocd_sink_model (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  input  wire logic   ch2_in,
  input  wire logic   ch3_in,
  output logic [15:0] count_out,
  output logic        split_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        split;
  } ocd_sink_t;
  ocd_sink_t st;
  ocd_sink_t next_st;
  always_comb begin
    next_st = st;
    if (ch2_in === 1'b1) next_st.cnt = st.cnt + 16'h0001;
    // latches until reset: one cycle with ch2 and ch3 differing means the pair lost lock
    if (ch2_in !== ch3_in) next_st.split = 1'b1;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) st <= '0;
    else st <= next_st;
  end
  assign count_out = st.cnt;
  assign split_out = st.split;
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the shared divider and channel 4 control block
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst, psel, pen, pwr, pready, perr, t23, ch2, ch3, c4t, drv, err;
  logic [7:0]  padr, rl;
  logic [31:0] pwd, prd, rd;
  logic [3:0]  pstb, stk;
  logic [1:0]  fo, po, no;
  logic [4:0]  tl;
  logic [15:0] cnt, base;
  logic        split;
  int          failures, cmp_count;
  logic [7:0]  codes [4] = '{8'hFF, 8'h00, 8'h01, 8'h03};

  ocd_output_ctrl dut_u (
    .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .APB_PSEL_IN(psel), .APB_PENABLE_IN(pen),
    .APB_PWRITE_IN(pwr), .APB_PADDR_IN(padr), .APB_PWDATA_IN(pwd), .APB_PSTRB_IN(pstb),
    .APB_PREADY_OUT(pready), .APB_PRDATA_OUT(prd), .APB_PSLVERR_OUT(perr),
    .CH23_SRC_TICK_IN(t23), .SYNTH1_TICK_IN(stk[0]), .SYNTH2_TICK_IN(stk[1]),
    .PRI_REF_TICK_IN(stk[2]), .SEC_REF_TICK_IN(stk[3]), .CH2_TICK_OUT(ch2), .CH3_TICK_OUT(ch3),
    .CH4_SRC_TICK_OUT(c4t), .CH4_DRV_EN_OUT(drv), .CH4_FORMAT_OUT(fo), .CH4_TAIL_MA_OUT(tl),
    .CH4_RLOAD_OHM_OUT(rl), .CH4_P_CTRL_OUT(po), .CH4_N_CTRL_OUT(no)
  );
  ocd_sink_model sink_u (
    .clk_in(clk), .rst_in(rst), .ch2_in(ch2), .ch3_in(ch3), .count_out(cnt), .split_out(split)
  );

  always #5 clk = ~clk;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] exp_out(input logic [1:0] f, input logic [1:0] a, input logic [1:0] b);
    logic [4:0] t;
    logic [7:0] r;
    case (a)
      2'h0: t = ocd_pkg::TAIL_4_MA;
      2'h1: t = ocd_pkg::TAIL_6_MA;
      2'h2: t = ocd_pkg::TAIL_8_MA;
      default: t = (f == ocd_pkg::FMT_HCSL) ? ocd_pkg::TAIL_16_MA : ocd_pkg::TAIL_8_MA;
    endcase
    case (b)
      2'h0: r = ocd_pkg::RLOAD_OPEN_OHM;
      2'h1: r = ocd_pkg::RLOAD_50_OHM;
      2'h2: r = ocd_pkg::RLOAD_100_OHM;
      default: r = ocd_pkg::RLOAD_200_OHM;
    endcase
    if (f != ocd_pkg::FMT_AC_DIFF && f != ocd_pkg::FMT_HCSL) t = 5'h00;
    if (f != ocd_pkg::FMT_HCSL) r = 8'h00;
    if (f != ocd_pkg::FMT_CMOS) a = 2'h0;
    if (f != ocd_pkg::FMT_CMOS) b = 2'h0;
    return {12'h000, f != 2'h0, f, t, r, a, b};
  endfunction

  task automatic summarize();
    $display("counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; a missing ready is cut short by the bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    pstb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("Error at %0t: no ready", $time);
      summarize();
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      t23 <= 1'b1;
    end
    @(posedge clk);
    t23 <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    padr = 8'h00;
    pwd = 32'h0;
    pstb = 4'h0;
    t23 = 1'b0;
    stk = 4'h0;
    failures = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    chk(drv, 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({12'h000, drv, fo, tl, rl, po, no}, exp_out(2'h1, 2'h2, 2'h0));
    apb(1'b0, ocd_pkg::ADDR_SHARED_DIV, 32'h0, 4'h0);
    chk(rd, 32'h03);
    apb(1'b0, ocd_pkg::ADDR_CH4_CTRL, 32'h0, 4'h0);
    chk(rd, 32'h18);
    base = cnt;
    ticks(11);
    chk(cnt - base, 32'h2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ocd_pkg::ADDR_SHARED_DIV, {24'h0, codes[i]}, 4'hF);
      apb(1'b0, ocd_pkg::ADDR_SHARED_DIV, 32'h0, 4'h0);
      chk(rd, {24'h0, codes[i]});
      base = cnt;
      ticks(3 * int'(codes[i]) + 2);
      chk(cnt - base, 32'h2);
    end
    chk(split, 32'h0);
    $display("test divider done");
    apb(1'b1, ocd_pkg::ADDR_SHARED_DIV, 32'hFFFFFF07, 4'hF);
    apb(1'b1, 8'h98, 32'h5A, 4'hF);
    chk(err, 32'h1);
    apb(1'b1, ocd_pkg::ADDR_SHARED_DIV, 32'h33, 4'h0);
    apb(1'b0, 8'h98, 32'h0, 4'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b0, ocd_pkg::ADDR_SHARED_DIV, 32'h0, 4'h0);
    chk({err, rd[30:0]}, 32'h07);
    $display("test refusal done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ocd_pkg::ADDR_CH4_CTRL, {24'h0, 2'(s), 6'h18}, 4'hF);
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        stk <= 4'h1 << k;
        @(posedge clk);
        stk <= 4'h0;
        #1 chk(c4t, k == s);
      end
    end
    $display("test source done");
    for (int v = 0; v < 64; v++) begin
      apb(1'b1, ocd_pkg::ADDR_CH4_CTRL, v, 4'hF);
      apb(1'b0, ocd_pkg::ADDR_CH4_CTRL, 32'h0, 4'h0);
      chk(rd, v);
      repeat (2) @(posedge clk);
      #1 chk({12'h000, drv, fo, tl, rl, po, no}, exp_out(v[5:4], v[3:2], v[1:0]));
    end
    $display("test format done");
    // a reset in mid-run must bring both registers back from their last written values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({12'h000, drv, fo, tl, rl, po, no}, exp_out(2'h1, 2'h2, 2'h0));
    apb(1'b0, ocd_pkg::ADDR_SHARED_DIV, 32'h0, 4'h0);
    chk(rd, {24'h0, ocd_pkg::RST_SHARED_DIV});
    apb(1'b0, ocd_pkg::ADDR_CH4_CTRL, 32'h0, 4'h0);
    chk(rd, {24'h0, ocd_pkg::RST_CH4_CTRL});
    $display("test mid-run reset done");
    summarize();
  end
endmodule

// ===== inc/ocd_pkg.sv
// constants shared by the output channel divider and control logic
package ocd_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int          APB_ADDR_W      = 8;
  localparam int          APB_DATA_W      = 32;
  localparam int          REG_W           = 8;
  localparam logic [5:0]  IDX_SHARED_DIV  = 6'h24;
  localparam logic [5:0]  IDX_CH4_CTRL    = 6'h25;
  localparam logic [7:0]  ADDR_SHARED_DIV = {IDX_SHARED_DIV, 2'h0};
  localparam logic [7:0]  ADDR_CH4_CTRL   = {IDX_CH4_CTRL, 2'h0};
  localparam logic [7:0]  RST_SHARED_DIV  = 8'h03;
  localparam logic [7:0]  RST_CH4_CTRL    = 8'h18;

  // ************************************************************
  // channel 4 control field positions
  // ************************************************************
  localparam int          SRC_LSB         = 6;
  localparam int          FMT_LSB         = 4;
  localparam int          MODE_A_LSB      = 2;
  localparam int          MODE_B_LSB      = 0;

  // ************************************************************
  // field encodings
  // ************************************************************
  localparam logic [1:0]  SRC_SYNTH1      = 2'h0;
  localparam logic [1:0]  SRC_SYNTH2      = 2'h1;
  localparam logic [1:0]  SRC_PRI_REF     = 2'h2;
  localparam logic [1:0]  SRC_SEC_REF     = 2'h3;
  localparam logic [1:0]  FMT_OFF         = 2'h0;
  localparam logic [1:0]  FMT_AC_DIFF     = 2'h1;
  localparam logic [1:0]  FMT_HCSL        = 2'h2;
  localparam logic [1:0]  FMT_CMOS        = 2'h3;
  localparam logic [1:0]  PIN_TRISTATE    = 2'h0;
  localparam logic [1:0]  PIN_LOW         = 2'h1;
  localparam logic [1:0]  PIN_INVERTED    = 2'h2;
  localparam logic [1:0]  PIN_TRUE        = 2'h3;

  // ************************************************************
  // driver strengths
  // ************************************************************
  localparam logic [4:0]  TAIL_NONE_MA    = 5'h00;
  localparam logic [4:0]  TAIL_4_MA       = 5'h04;
  localparam logic [4:0]  TAIL_6_MA       = 5'h06;
  localparam logic [4:0]  TAIL_8_MA       = 5'h08;
  localparam logic [4:0]  TAIL_16_MA      = 5'h10;
  localparam logic [7:0]  RLOAD_OPEN_OHM  = 8'h00;
  localparam logic [7:0]  RLOAD_50_OHM    = 8'h32;
  localparam logic [7:0]  RLOAD_100_OHM   = 8'h64;
  localparam logic [7:0]  RLOAD_200_OHM   = 8'hC8;

endpackage

// ===== verilog/ocd_output_ctrl.sv
// register block for the shared channel 2/3 divider and channel 4 output control
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps

// Notes on behaviour
// - one divider setting drives channels 2 and 3
// - divide ratio equals divider code plus one
// - channel 4 source: synth1, synth2, primary, secondary
// - channel 4 format: off, AC differential, HCSL, CMOS
// - mode A: tail current, or CMOS positive pin
// - mode B: HCSL load, or CMOS negative pin
module ocd_output_ctrl (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        APB_PSEL_IN,
  input  wire logic        APB_PENABLE_IN,
  input  wire logic        APB_PWRITE_IN,
  input  wire logic [7:0]  APB_PADDR_IN,
  input  wire logic [31:0] APB_PWDATA_IN,
  input  wire logic [3:0]  APB_PSTRB_IN,
  output logic             APB_PREADY_OUT,
  output logic [31:0]      APB_PRDATA_OUT,
  output logic             APB_PSLVERR_OUT,
  input  wire logic        CH23_SRC_TICK_IN,
  input  wire logic        SYNTH1_TICK_IN,
  input  wire logic        SYNTH2_TICK_IN,
  input  wire logic        PRI_REF_TICK_IN,
  input  wire logic        SEC_REF_TICK_IN,
  output logic             CH2_TICK_OUT,
  output logic             CH3_TICK_OUT,
  output logic             CH4_SRC_TICK_OUT,
  output logic             CH4_DRV_EN_OUT,
  output logic [1:0]       CH4_FORMAT_OUT,
  output logic [4:0]       CH4_TAIL_MA_OUT,
  output logic [7:0]       CH4_RLOAD_OHM_OUT,
  output logic [1:0]       CH4_P_CTRL_OUT,
  output logic [1:0]       CH4_N_CTRL_OUT
);

  typedef struct packed {
    logic [7:0]  shared_divider_ch2_ch3;
    logic [7:0]  channel4_output_control;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        ch4_tick;
    logic        drv_en;
    logic [1:0]  fmt;
    logic [4:0]  tail;
    logic [7:0]  rload;
    logic [1:0]  p_ctl;
    logic [1:0]  n_ctl;
  } ocd_top_st_t;

  ocd_top_st_t st;
  ocd_top_st_t next_st;

  logic [1:0] ch4_source_select;
  logic [1:0] ch4_format;
  logic [1:0] ch4_drive_mode_a;
  logic [1:0] ch4_drive_mode_b;
  logic       src_tick_now;
  logic       apb_setup;
  logic       apb_done;
  logic       addr_div;
  logic       addr_ctl;

  assign ch4_source_select = st.channel4_output_control[ocd_pkg::SRC_LSB +: 2];
  assign ch4_format        = st.channel4_output_control[ocd_pkg::FMT_LSB +: 2];
  assign ch4_drive_mode_a  = st.channel4_output_control[ocd_pkg::MODE_A_LSB +: 2];
  assign ch4_drive_mode_b  = st.channel4_output_control[ocd_pkg::MODE_B_LSB +: 2];
  assign apb_setup         = APB_PSEL_IN && !APB_PENABLE_IN;
  assign apb_done          = APB_PSEL_IN && APB_PENABLE_IN && st.pready;
  assign addr_div          = APB_PADDR_IN == ocd_pkg::ADDR_SHARED_DIV;
  assign addr_ctl          = APB_PADDR_IN == ocd_pkg::ADDR_CH4_CTRL;

  // ************************************************************
  // channel 4 source routing
  // ************************************************************
  always_comb begin
    case (ch4_source_select)
      ocd_pkg::SRC_SYNTH1:  src_tick_now = SYNTH1_TICK_IN;
      ocd_pkg::SRC_SYNTH2:  src_tick_now = SYNTH2_TICK_IN;
      ocd_pkg::SRC_PRI_REF: src_tick_now = PRI_REF_TICK_IN;
      default:              src_tick_now = SEC_REF_TICK_IN;
    endcase
  end

  // ************************************************************
  // register access and driver decode
  // ************************************************************
  always_comb begin
    next_st = st;
    // pready rises for the one access cycle after every setup, so zero wait states
    next_st.pready  = apb_setup;
    next_st.pslverr = apb_setup && !(addr_div || addr_ctl);
    if (apb_setup && !APB_PWRITE_IN) begin
      next_st.prdata = 32'h0000_0000;
      if (addr_div) begin
        next_st.prdata[7:0] = st.shared_divider_ch2_ch3;
      end else if (addr_ctl) begin
        next_st.prdata[7:0] = st.channel4_output_control;
      end
    end
    // only byte lane 0 carries register bits; other lanes are ignored
    if (apb_done && APB_PWRITE_IN && APB_PSTRB_IN[0]) begin
      if (addr_div) begin
        next_st.shared_divider_ch2_ch3 = APB_PWDATA_IN[7:0];
      end else if (addr_ctl) begin
        next_st.channel4_output_control = APB_PWDATA_IN[7:0];
      end
    end

    next_st.ch4_tick = src_tick_now;
    next_st.fmt      = ch4_format;
    next_st.drv_en   = ch4_format != ocd_pkg::FMT_OFF;
    next_st.tail     = ocd_pkg::TAIL_NONE_MA;
    next_st.rload    = ocd_pkg::RLOAD_OPEN_OHM;
    next_st.p_ctl    = ocd_pkg::PIN_TRISTATE;
    next_st.n_ctl    = ocd_pkg::PIN_TRISTATE;
    case (ch4_format)
      ocd_pkg::FMT_AC_DIFF, ocd_pkg::FMT_HCSL: begin
        case (ch4_drive_mode_a)
          2'h0:    next_st.tail = ocd_pkg::TAIL_4_MA;
          2'h1:    next_st.tail = ocd_pkg::TAIL_6_MA;
          2'h2:    next_st.tail = ocd_pkg::TAIL_8_MA;
          default: next_st.tail = (ch4_format == ocd_pkg::FMT_HCSL) ? ocd_pkg::TAIL_16_MA : ocd_pkg::TAIL_8_MA;
        endcase
        // load resistance only has meaning for the HCSL driver
        if (ch4_format == ocd_pkg::FMT_HCSL) begin
          case (ch4_drive_mode_b)
            2'h0:    next_st.rload = ocd_pkg::RLOAD_OPEN_OHM;
            2'h1:    next_st.rload = ocd_pkg::RLOAD_50_OHM;
            2'h2:    next_st.rload = ocd_pkg::RLOAD_100_OHM;
            default: next_st.rload = ocd_pkg::RLOAD_200_OHM;
          endcase
        end
      end
      ocd_pkg::FMT_CMOS: begin
        next_st.p_ctl = ch4_drive_mode_a;
        next_st.n_ctl = ch4_drive_mode_b;
      end
      default: begin
        next_st.drv_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st <= '0;
      st.shared_divider_ch2_ch3 <= ocd_pkg::RST_SHARED_DIV;
      st.channel4_output_control <= ocd_pkg::RST_CH4_CTRL;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // shared channel 2/3 divider
  // ************************************************************
  ocd_tick_div #(
    .W (ocd_pkg::REG_W)
  ) u_div (
    .clk_in        (CORE_CLK_IN),
    .rst_in        (SYS_RST_IN),
    .tick_in       (CH23_SRC_TICK_IN),
    .ratio_code_in (st.shared_divider_ch2_ch3),
    .pulse_a_out   (CH2_TICK_OUT),
    .pulse_b_out   (CH3_TICK_OUT)
  );

  assign APB_PREADY_OUT    = st.pready;
  assign APB_PRDATA_OUT    = st.prdata;
  assign APB_PSLVERR_OUT   = st.pslverr;
  assign CH4_SRC_TICK_OUT  = st.ch4_tick;
  assign CH4_DRV_EN_OUT    = st.drv_en;
  assign CH4_FORMAT_OUT    = st.fmt;
  assign CH4_TAIL_MA_OUT   = st.tail;
  assign CH4_RLOAD_OHM_OUT = st.rload;
  assign CH4_P_CTRL_OUT    = st.p_ctl;
  assign CH4_N_CTRL_OUT    = st.n_ctl;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_div_write;
    apb_done && APB_PWRITE_IN && APB_PSTRB_IN[0] && addr_div;
  endsequence

  sequence s_ctl_write;
    apb_done && APB_PWRITE_IN && APB_PSTRB_IN[0] && addr_ctl;
  endsequence

  a_div_write_take: assert property (
    s_div_write |=> st.shared_divider_ch2_ch3 == $past(APB_PWDATA_IN[7:0]))
    else $error("shared divider write lost");
  a_ctl_write_take: assert property (
    s_ctl_write |=> st.channel4_output_control == $past(APB_PWDATA_IN[7:0]))
    else $error("channel 4 control write lost");
  a_src_route_cycle: assert property (CH4_SRC_TICK_OUT == $past(src_tick_now))
    else $error("channel 4 source routed wrongly");
  a_fmt_off_driver: assert property (
    $past(ch4_format) == ocd_pkg::FMT_OFF |-> !CH4_DRV_EN_OUT && CH4_TAIL_MA_OUT == ocd_pkg::TAIL_NONE_MA)
    else $error("disabled driver still active");
  a_tail_hcsl_max: assert property (
    $past(ch4_format) == ocd_pkg::FMT_HCSL && $past(ch4_drive_mode_a) == 2'h3
    |-> CH4_TAIL_MA_OUT == ocd_pkg::TAIL_16_MA)
    else $error("HCSL tail current wrong");
  a_tail_ac_top: assert property (
    $past(ch4_format) == ocd_pkg::FMT_AC_DIFF && $past(ch4_drive_mode_a) == 2'h3
    |-> CH4_TAIL_MA_OUT == ocd_pkg::TAIL_8_MA && CH4_RLOAD_OHM_OUT == ocd_pkg::RLOAD_OPEN_OHM)
    else $error("AC differential tail or load wrong");
  a_cmos_pos_pin: assert property (
    $past(ch4_format) == ocd_pkg::FMT_CMOS
    |-> CH4_P_CTRL_OUT == $past(ch4_drive_mode_a) && CH4_TAIL_MA_OUT == ocd_pkg::TAIL_NONE_MA)
    else $error("CMOS positive pin wrong");
  a_rload_hcsl_mid: assert property (
    $past(ch4_format) == ocd_pkg::FMT_HCSL && $past(ch4_drive_mode_b) == 2'h2
    |-> CH4_RLOAD_OHM_OUT == ocd_pkg::RLOAD_100_OHM)
    else $error("HCSL load wrong");
  a_cmos_neg_pin: assert property (
    $past(ch4_format) == ocd_pkg::FMT_CMOS
    |-> CH4_N_CTRL_OUT == $past(ch4_drive_mode_b) && CH4_RLOAD_OHM_OUT == ocd_pkg::RLOAD_OPEN_OHM)
    else $error("CMOS negative pin wrong");
  a_apb_ready_once: assert property (apb_setup |=> APB_PREADY_OUT ##1 !APB_PREADY_OUT)
    else $error("pready not a single access cycle");
  // an unmapped access must be flagged in the very cycle that pready answers it
  a_unmapped_err: assert property (apb_setup && !(addr_div || addr_ctl) |=> APB_PSLVERR_OUT && APB_PREADY_OUT)
    else $error("unmapped access not flagged");
  a_pair_locked: assert property (CH2_TICK_OUT |-> CH3_TICK_OUT)
    else $error("channel 3 missed a shared tick");

endmodule

// ===== verilog/ocd_tick_div.sv
// shared divider that turns source ticks into channel 2 and 3 ticks
`timescale 1ns/100ps
module ocd_tick_div #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio_code_in,
  output logic              pulse_a_out,
  output logic              pulse_b_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] last_code;
    logic         pulse_a;
    logic         pulse_b;
  } ocd_div_st_t;

  ocd_div_st_t st;
  ocd_div_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.pulse_a = 1'b0;
    next_st.pulse_b = 1'b0;
    next_st.last_code = ratio_code_in;
    // a new ratio restarts the count so a shrink never waits a full wrap
    if (ratio_code_in != st.last_code) begin
      next_st.cnt = '0;
    end else if (tick_in) begin
      if (st.cnt >= ratio_code_in) begin
        next_st.cnt = '0;
        next_st.pulse_a = 1'b1;
        next_st.pulse_b = 1'b1;
      end else begin
        next_st.cnt = st.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_a_out = st.pulse_a;
  assign pulse_b_out = st.pulse_b;

  // ************************************************************
  // checks
  // ************************************************************
  logic [W:0] chk_ticks;
  logic       chk_clean;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chk_ticks <= '0;
      chk_clean <= 1'b0;
    end else if (ratio_code_in != st.last_code) begin
      chk_ticks <= '0;
      chk_clean <= 1'b0;
    end else if (st.pulse_a) begin
      chk_ticks <= {{W{1'b0}}, tick_in};
      chk_clean <= 1'b1;
    end else begin
      chk_ticks <= chk_ticks + {{W{1'b0}}, tick_in};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_div_ratio_count: assert property (
    st.pulse_a && chk_clean && $stable(ratio_code_in) |-> chk_ticks == {1'b0, ratio_code_in} + {{W{1'b0}}, 1'b1})
    else $error("divider ratio is not code plus one");
  a_div_pair_lock: assert property (pulse_a_out == pulse_b_out)
    else $error("channel 2 and 3 ticks differ");
  a_div_from_src: assert property (pulse_a_out |-> $past(tick_in))
    else $error("divided tick without a source tick");

endmodule
